// file: rtl/pcrc_top.sv
`timescale 1ns/1ps

// What this block does
// - idle_stop set halts the block in idle; clear keeps it running
// - control bits 12:8 report valid words, up to 8 or 16
// - full flag bit 7 set when count equals fifo depth
// - empty flag bit 6 set at zero count; reads set after reset
// - shift_go bit 4 turns the serial shifter on or off
// - poly_len bits 3:0 hold polynomial length minus one, also word width
// - tap bit n in 15:1 adds feedback xor at term x^n; bit 0 reads zero
// - x^0 term always applied; top term applied without a tap bit
// - fifo is 8 deep when poly_len above 7, else 16 deep
// - data sits in low poly_len+1 bits; byte is smallest write
// - count increments when the word's most significant byte is written
// - shifter runs while shift_go and count nonzero; pops each word
// - one bit per clock, poly_len+1 cycles per word
// - write while full wraps count to zero, no interrupt
// - interrupt pulse when count goes from one to zero
// - sleep freezes the shifter in its current state; register writes still take effect
// - idle with idle_stop acts as sleep; pending interrupt still goes out

module pcrc_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [1:0] reg_byte_en_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic sleep_in,
    input wire logic idle_in,
    output logic [15:0] reg_rdata_out,
    output logic crc_irq_out
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // fifo depth for a given polynomial length
    function automatic logic [4:0] fifo_depth(input logic [3:0] len);
        if (len > pcrc_pkg::POLY_LEN_SPLIT) begin
            fifo_depth = pcrc_pkg::DEPTH_LONG_WORD;
        end else begin
            fifo_depth = pcrc_pkg::DEPTH_SHORT_WORD;
        end
    endfunction

    // pointer advance, wrapping at the active depth
    function automatic logic [3:0] ptr_step(input logic [3:0] ptr, input logic [3:0] len);
        logic [4:0] wide;
        wide = {1'b0, ptr} + 5'h01;
        if (wide >= fifo_depth(len)) begin
            ptr_step = 4'h0;
        end else begin
            ptr_step = wide[3:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic idle_stop;
    logic shift_go;
    logic [3:0] poly_len;
    logic [15:0] taps;
    logic [15:0] word_hold;
    logic [15:0] fifo_mem [pcrc_pkg::FIFO_SLOTS];
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [4:0] word_count;
    logic [4:0] next_word_count;
    logic [3:0] bits_done;
    logic [15:0] crc_value;

    logic wr_control;
    logic wr_taps;
    logic wr_input;
    logic wr_result;
    logic msb_lane_hit;
    logic [15:0] push_word;
    logic push;
    logic overflow;
    logic fifo_full;
    logic fifo_empty;
    logic frozen;
    logic shift_active;
    logic last_bit;
    logic pop;
    logic [3:0] bit_sel;
    logic shift_bit;
    logic [15:0] control_view;

    // ----------------------------------------------------------------
    // power save and status decode
    // ----------------------------------------------------------------

    // sleep always freezes; idle only when idle_stop is set
    assign frozen = sleep_in | (idle_in & idle_stop);

    // flags follow the live word count
    assign fifo_full = (word_count == fifo_depth(poly_len));
    assign fifo_empty = (word_count == 5'h00);

    // ----------------------------------------------------------------
    // register write decode
    // ----------------------------------------------------------------
    assign wr_control = reg_wr_in & (reg_addr_in == pcrc_pkg::ADDR_CONTROL);
    assign wr_taps = reg_wr_in & (reg_addr_in == pcrc_pkg::ADDR_TAPS);
    assign wr_input = reg_wr_in & (reg_addr_in == pcrc_pkg::ADDR_INPUT_WORD);
    assign wr_result = reg_wr_in & (reg_addr_in == pcrc_pkg::ADDR_RESULT);

    // the word completes when the lane holding its top bit is written
    assign msb_lane_hit = (poly_len > pcrc_pkg::POLY_LEN_SPLIT) ?
                          reg_byte_en_in[1] : reg_byte_en_in[0];

    // merge the written lanes with bytes captured by earlier writes
    assign push_word = {reg_byte_en_in[1] ? reg_wdata_in[15:8] : word_hold[15:8],
                        reg_byte_en_in[0] ? reg_wdata_in[7:0] : word_hold[7:0]};

    assign push = wr_input & msb_lane_hit;
    assign overflow = push & fifo_full;

    // ----------------------------------------------------------------
    // serial shifter decode
    // ----------------------------------------------------------------

    // shifts only while enabled, words pending and not frozen
    assign shift_active = shift_go & ~fifo_empty & ~frozen;

    // top bit of the word goes first, one bit per clock
    assign bit_sel = poly_len - bits_done;
    assign shift_bit = fifo_mem[rd_ptr][bit_sel];
    assign last_bit = (bits_done == poly_len);
    assign pop = shift_active & last_bit & ~overflow;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------

    // writable fields; count and flags are read-only
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            idle_stop <= 1'b0;
            shift_go <= 1'b0;
            poly_len <= pcrc_pkg::POLY_LEN_RESET;
        end else if (wr_control) begin
            if (reg_byte_en_in[1]) begin
                idle_stop <= reg_wdata_in[pcrc_pkg::CTRL_IDLE_STOP_BIT];
            end
            if (reg_byte_en_in[0]) begin
                shift_go <= reg_wdata_in[pcrc_pkg::CTRL_SHIFT_GO_BIT];
                poly_len <= reg_wdata_in[pcrc_pkg::CTRL_POLY_LEN_MSB:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // polynomial tap register
    // ----------------------------------------------------------------

    // bit 0 is never stored, so it reads back as zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            taps <= pcrc_pkg::TAPS_RESET;
        end else if (wr_taps) begin
            if (reg_byte_en_in[1]) begin
                taps[15:8] <= reg_wdata_in[15:8];
            end
            if (reg_byte_en_in[0]) begin
                taps[7:0] <= reg_wdata_in[7:0] & pcrc_pkg::TAPS_WRITE_MASK[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // input word assembly
    // ----------------------------------------------------------------

    // keeps bytes of a word that is written one lane at a time
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            word_hold <= 16'h0000;
        end else if (wr_input) begin
            word_hold <= push_word;
        end
    end

    // ----------------------------------------------------------------
    // fifo storage
    // ----------------------------------------------------------------

    // words are written at the write pointer; storage needs no reset
    always_ff @(posedge clk_in) begin
        if (push & ~overflow) begin
            fifo_mem[wr_ptr] <= push_word;
        end
    end

    // ----------------------------------------------------------------
    // fifo pointers
    // ----------------------------------------------------------------

    // a write into a full fifo restarts both pointers as if empty
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
        end else if (overflow) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_step(wr_ptr, poly_len);
            end
            if (pop) begin
                rd_ptr <= ptr_step(rd_ptr, poly_len);
            end
        end
    end

    // ----------------------------------------------------------------
    // valid word count
    // ----------------------------------------------------------------

    // wrap on overflow, otherwise add pushes and remove pops
    always_comb begin
        next_word_count = word_count;
        if (overflow) begin
            next_word_count = 5'h00;
        end else if (push & ~pop) begin
            next_word_count = word_count + 5'h01;
        end else if (pop & ~push) begin
            next_word_count = word_count - 5'h01;
        end
    end

    // count is visible on the read that follows the write cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            word_count <= pcrc_pkg::COUNT_RESET;
        end else begin
            word_count <= next_word_count;
        end
    end

    // ----------------------------------------------------------------
    // bit position within the head word
    // ----------------------------------------------------------------

    // counts bits already sent; restarts on every new word
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bits_done <= 4'h0;
        end else if (overflow) begin
            bits_done <= 4'h0;
        end else if (shift_active) begin
            if (last_bit) begin
                bits_done <= 4'h0;
            end else begin
                bits_done <= bits_done + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt event
    // ----------------------------------------------------------------

    // one-cycle pulse on the one-to-zero step of the count; an event
    // raised just before a freeze still leaves on the next edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            crc_irq_out <= 1'b0;
        end else begin
            crc_irq_out <= (word_count == 5'h01) & (next_word_count == 5'h00);
        end
    end

    // ----------------------------------------------------------------
    // crc engine
    // ----------------------------------------------------------------

    // steps once per shifted bit; software may seed it by writing
    pcrc_lfsr u_lfsr (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .step_in(shift_active & ~overflow),
        .bit_in(shift_bit),
        .poly_len_in(poly_len),
        .taps_in(taps),
        .load_in(wr_result),
        .load_value_in(reg_wdata_in),
        .crc_out(crc_value)
    );

    // ----------------------------------------------------------------
    // register read path
    // ----------------------------------------------------------------

    // assembled control word; unused bits read zero
    always_comb begin
        control_view = 16'h0000;
        control_view[pcrc_pkg::CTRL_IDLE_STOP_BIT] = idle_stop;
        control_view[pcrc_pkg::CTRL_COUNT_MSB:pcrc_pkg::CTRL_COUNT_LSB] = word_count;
        control_view[pcrc_pkg::CTRL_FULL_BIT] = fifo_full;
        control_view[pcrc_pkg::CTRL_EMPTY_BIT] = fifo_empty;
        control_view[pcrc_pkg::CTRL_SHIFT_GO_BIT] = shift_go;
        control_view[pcrc_pkg::CTRL_POLY_LEN_MSB:0] = poly_len;
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                pcrc_pkg::ADDR_CONTROL: begin
                    reg_rdata_out <= control_view;
                end
                pcrc_pkg::ADDR_TAPS: begin
                    reg_rdata_out <= taps;
                end
                pcrc_pkg::ADDR_INPUT_WORD: begin
                    reg_rdata_out <= word_hold;
                end
                pcrc_pkg::ADDR_RESULT: begin
                    reg_rdata_out <= crc_value;
                end
                default: begin
                    reg_rdata_out <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule

// file: common/pcrc_pkg.sv
package pcrc_pkg;

    // ----------------------------------------------------------------
    // register map (word index on the register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_TAPS = 4'h1;
    localparam logic [3:0] ADDR_INPUT_WORD = 4'h2;
    localparam logic [3:0] ADDR_RESULT = 4'h3;

    // ----------------------------------------------------------------
    // control register field positions
    // ----------------------------------------------------------------
    localparam int CTRL_IDLE_STOP_BIT = 13;
    localparam int CTRL_COUNT_MSB = 12;
    localparam int CTRL_COUNT_LSB = 8;
    localparam int CTRL_FULL_BIT = 7;
    localparam int CTRL_EMPTY_BIT = 6;
    localparam int CTRL_SHIFT_GO_BIT = 4;
    localparam int CTRL_POLY_LEN_MSB = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] POLY_LEN_RESET = 4'h0;
    localparam logic [15:0] TAPS_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [4:0] COUNT_RESET = 5'h00;

    // ----------------------------------------------------------------
    // fifo sizing
    // ----------------------------------------------------------------
    localparam logic [3:0] POLY_LEN_SPLIT = 4'h7;
    localparam logic [4:0] DEPTH_LONG_WORD = 5'h08;
    localparam logic [4:0] DEPTH_SHORT_WORD = 5'h10;
    localparam int FIFO_SLOTS = 16;

    // tap bit 0 is not implemented and reads as zero
    localparam logic [15:0] TAPS_WRITE_MASK = 16'hfffe;

endpackage

// file: rtl/pcrc_lfsr.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// crc engine: galois shift register of programmable length
// ----------------------------------------------------------------
module pcrc_lfsr (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic step_in,
    input wire logic bit_in,
    input wire logic [3:0] poly_len_in,
    input wire logic [15:0] taps_in,
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    output logic [15:0] crc_out
);

    logic [15:0] next_crc;
    logic feedback;

    // one shift step: x^0 always fed back, top term implicit
    always_comb begin
        feedback = bit_in ^ crc_out[poly_len_in];
        next_crc = 16'h0000;
        next_crc[0] = feedback;
        for (int i = 1; i < 16; i++) begin
            if (i <= int'(poly_len_in)) begin
                next_crc[i] = crc_out[i - 1] ^ (taps_in[i] & feedback);
            end
        end
    end

    // state register, seeded by software through the result port
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            crc_out <= pcrc_pkg::RESULT_RESET;
        end else if (load_in) begin
            crc_out <= load_value_in;
        end else if (step_in) begin
            crc_out <= next_crc;
        end
    end

endmodule

// file: verif/pcrc_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the crc block
// ----------------------------------------------------------------
module pcrc_chk (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [1:0] reg_byte_en_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic sleep_in,
    input wire logic idle_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic crc_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    logic rd_ctrl;
    logic [4:0] depth;

    // marks the cycle that carries control read data
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_ctrl <= 1'b0;
        end else begin
            rd_ctrl <= reg_rd_in && reg_addr_in == pcrc_pkg::ADDR_CONTROL;
        end
    end

    // fifo depth implied by the length field being read
    assign depth = (reg_rdata_out[3:0] > pcrc_pkg::POLY_LEN_SPLIT) ?
        pcrc_pkg::DEPTH_LONG_WORD : pcrc_pkg::DEPTH_SHORT_WORD;

    a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > pcrc_pkg::ADDR_RESULT
        |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
    a_taps_bit_zero: assert property (reg_rd_in && reg_addr_in == pcrc_pkg::ADDR_TAPS
        |=> !reg_rdata_out[0]) else $error("tap bit 0 reads one");
    a_empty_flag_count: assert property (rd_ctrl |->
        reg_rdata_out[6] == (reg_rdata_out[12:8] == 5'h00)) else $error("empty flag wrong");
    a_full_flag_depth: assert property (rd_ctrl |->
        reg_rdata_out[7] == (reg_rdata_out[12:8] == depth)) else $error("full flag wrong");
    a_count_depth_limit: assert property (rd_ctrl |-> reg_rdata_out[12:8] <= depth)
        else $error("word count above depth");
    a_ctrl_unused_zero: assert property (rd_ctrl |->
        reg_rdata_out[15:14] == 2'b00 && !reg_rdata_out[5]) else $error("unused bit set");
    a_ctrl_write_echo: assert property (reg_wr_in && reg_addr_in == pcrc_pkg::ADDR_CONTROL
        && reg_byte_en_in == 2'b11 ##2 reg_rd_in && reg_addr_in == pcrc_pkg::ADDR_CONTROL
        |=> (reg_rdata_out & 16'h201f) == ($past(reg_wdata_in, 3) & 16'h201f))
        else $error("control fields not kept");
    a_irq_single_pulse: assert property (crc_irq_out |=> !crc_irq_out)
        else $error("interrupt longer than one cycle");
    a_sleep_no_irq: assert property (sleep_in [*4] |-> !crc_irq_out)
        else $error("interrupt while asleep");

    c_irq: cover property (crc_irq_out);
    c_full_read: cover property (rd_ctrl && reg_rdata_out[7]);
    c_sleep_idle: cover property (sleep_in ##1 idle_in);
endmodule

bind pcrc_top pcrc_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_byte_en_in(reg_byte_en_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .sleep_in(sleep_in), .idle_in(idle_in),
    .reg_rdata_out(reg_rdata_out), .crc_irq_out(crc_irq_out));

// file: verif/pcrc_tb_top.sv
`timescale 1ns/1ps

module pcrc_tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [1:0] reg_byte_en_in = 2'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic idle_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic crc_irq_out;
    int n_errors = 0;
    int samples_checked = 0;
    int irq_seen = 0;
    int n;
    logic rd_q = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] taps, crc_exp, w;

    always #4 clk_in = ~clk_in;

    pcrc_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_byte_en_in(reg_byte_en_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .sleep_in(sleep_in), .idle_in(idle_in),
        .reg_rdata_out(reg_rdata_out), .crc_irq_out(crc_irq_out));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // interrupt tallies and cycle counts are whole numbers
    task automatic check_irq(input string what, input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_byte_en_in <= be;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // notes the expected data, the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask

    // counts cycles until the interrupt pulse, bounded
    task automatic wait_irq();
        n = 0;
        while (crc_irq_out !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
    endtask

    // msb-first galois register, bits above the length cleared
    function automatic logic [15:0] crc_ref(logic [15:0] c, logic [15:0] d,
                                            logic [15:0] t, int pl);
        logic fb;
        logic [15:0] nx;
        for (int b = pl; b >= 0; b--) begin
            fb = d[b] ^ c[pl];
            nx = 16'h0000;
            nx[0] = fb;
            for (int i = 1; i <= pl; i++) nx[i] = c[i-1] ^ (t[i] & fb);
            c = nx;
        end
        return c;
    endfunction

    // read data monitor and interrupt counter
    always @(posedge clk_in) begin
        if (rd_q) check("read", reg_rdata_out, exp_q.pop_front());
        rd_q <= reg_rd_in;
        if (crc_irq_out === 1'b1) irq_seen++;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(50));
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(pcrc_pkg::ADDR_CONTROL, 16'h0040);
        rd(pcrc_pkg::ADDR_RESULT, 16'h0000);
        rd(4'h9, 16'h0000);
        wr(pcrc_pkg::ADDR_TAPS, 16'hffff, 2'b11);
        rd(pcrc_pkg::ADDR_TAPS, 16'hfffe);
        $display("test reset_taps done");
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0003, 2'b11);
        for (int k = 1; k <= 16; k++) begin
            wr(pcrc_pkg::ADDR_INPUT_WORD, 16'($urandom()), 2'b01);
            w = 16'h0003 | 16'(k << 8) | (k == 16 ? 16'h0080 : 16'h0000);
            rd(pcrc_pkg::ADDR_CONTROL, w);
        end
        wr(pcrc_pkg::ADDR_INPUT_WORD, 16'h00a5, 2'b01);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h0043);
        check_irq("irq count", irq_seen, 0);
        $display("test short_fill done");
        wr(pcrc_pkg::ADDR_CONTROL, 16'h000f, 2'b11);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h004f);
        wr(pcrc_pkg::ADDR_INPUT_WORD, 16'h0012, 2'b01);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h004f);
        wr(pcrc_pkg::ADDR_INPUT_WORD, 16'h3400, 2'b10);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h010f);
        repeat (7) wr(pcrc_pkg::ADDR_INPUT_WORD, 16'($urandom()), 2'b11);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h088f);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h001f, 2'b11);
        wait_irq();
        rd(pcrc_pkg::ADDR_CONTROL, 16'h005f);
        check_irq("irq count", irq_seen, 1);
        $display("test long_fill done");
        taps = 16'($urandom()) & 16'hfffe;
        crc_exp = 16'($urandom()) & 16'h000f;
        wr(pcrc_pkg::ADDR_TAPS, taps, 2'b11);
        wr(pcrc_pkg::ADDR_RESULT, crc_exp, 2'b11);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0013, 2'b11);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h0053);
        w = 16'($urandom());
        crc_exp = crc_ref(crc_exp, w, taps, 3);
        wr(pcrc_pkg::ADDR_INPUT_WORD, w, 2'b01);
        wait_irq();
        check_irq("cycles to irq", n, 5);
        rd(pcrc_pkg::ADDR_RESULT, crc_exp);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0007, 2'b11);
        for (int k = 0; k < 2; k++) begin
            w = 16'($urandom());
            crc_exp = crc_ref(crc_exp, w, taps, 7);
            wr(pcrc_pkg::ADDR_INPUT_WORD, w, 2'b11);
        end
        rd(pcrc_pkg::ADDR_CONTROL, 16'h0207);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0017, 2'b11);
        wait_irq();
        check_irq("cycles to irq", n, 17);
        rd(pcrc_pkg::ADDR_RESULT, crc_exp);
        $display("test crc_value done");
        wr(pcrc_pkg::ADDR_CONTROL, 16'h2003, 2'b11);
        for (int k = 0; k < 2; k++) begin
            w = 16'($urandom());
            crc_exp = crc_ref(crc_exp, w, taps, 3);
            wr(pcrc_pkg::ADDR_INPUT_WORD, w, 2'b01);
        end
        @(posedge clk_in);
        sleep_in <= 1'b1;
        wr(pcrc_pkg::ADDR_CONTROL, 16'h2013, 2'b11);
        repeat (20) @(posedge clk_in);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h2213);
        sleep_in <= 1'b0;
        idle_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        rd(pcrc_pkg::ADDR_CONTROL, 16'h2213);
        wr(pcrc_pkg::ADDR_CONTROL, 16'h0013, 2'b11);
        wait_irq();
        idle_in <= 1'b0;
        rd(pcrc_pkg::ADDR_CONTROL, 16'h0053);
        rd(pcrc_pkg::ADDR_RESULT, crc_exp);
        check_irq("irq count", irq_seen, 4);
        $display("test power_save done");
        repeat (3) @(posedge clk_in);
        results();
    end
endmodule
